// ### design/pncc_top.sv
`timescale 1ns/1ps
// ==================================================
// Contract
// R1 - prescaler sequence ignored when prescaler reset rate is zero
// R2 - prescaler reset rate sets when prescaler sequence restarts
// R3 - prescaler divisor is the low five bits of its register
// R4 - feedback divisor used, ignored when feedback reset rate is zero; code uses the plain divisor then and ignores the sequence
// R5 - feedback sequence is the full eight-bit sequence register
// R6 - low three bits of bias register set feedback sequence restart rate
// R7 - host writes the bias register last when changing settings
// R8 - two-bit bias code selects oscillator current, 00 lowest, 11 highest
// R9 - host should program lowest bias when an external clock is used
// R10 - three-bit code selects vco range, higher codes higher frequency
// R11 - upper four bits set charge pump current, proportional to two plus code
// R12 - host keeps bit 3 of charge pump register zero
// R13 - force bit chooses oscillator at 0 or vco at 1 as system clock
// R14 - force bit clears on reset, power-down, or front end disabled
// R15 - pll stays powered until system clock is back on oscillator
// R16 - pll powered only when front end enabled and not powered down; code keeps it on for the hold and until the clock is back on the oscillator
// R17 - read-only lock bit reports pll lock
// R18 - oscillator passes through the prescaler to form the pll reference
// R19 - host enters divisor, sequence and rate settings over the serial port
// R20 - writes to unused bits are ignored
// R21 - control bit 7 enables the front end; 0 stops tx and rx clocks
// R22 - each divider alternates divisor and divisor plus one per sequence bit
// R23 - new divisor and sequence settings take effect on bias register write
module pncc_top
    import pncc_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // register port from the serial interface
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    // analog status
    input  wire logic       pll_lock_i,
    input  wire logic       sysclk_on_osc_i,
    // analog controls
    output logic      [1:0] osc_bias_o,
    output logic      [2:0] vco_range_o,
    output logic      [3:0] charge_pump_o,
    output logic            pll_power_on_o,
    output logic            sel_vco_o,
    output logic            front_end_enable_o,
    output logic            trx_clk_run_o,
    // divider ticks
    output logic            pll_ref_tick_o,
    output logic            pll_fb_tick_o
);
    import pncc_pkg::*;

    // ==================================================
    // shadow registers written by the host
    logic [7:0] ctrl;
    logic [7:0] pseq;
    logic [7:0] prate;
    logic [7:0] cpvco;
    logic [7:0] fbdiv;
    logic [7:0] fbseq;
    logic [7:0] oscbias;
    logic       frc_vco;
    logic       pwdn;
    logic [7:0] next_ctrl;
    logic [7:0] next_pseq;
    logic [7:0] next_prate;
    logic [7:0] next_cpvco;
    logic [7:0] next_fbdiv;
    logic [7:0] next_fbseq;
    logic [7:0] next_oscbias;
    logic       next_frc_vco;
    logic       next_pwdn;

    // registers that drive the dividers, updated together
    logic [7:0] act_pseq;
    logic [7:0] act_prate;
    logic [7:0] act_fbdiv;
    logic [7:0] act_fbseq;
    logic [2:0] act_fbrate;
    logic [7:0] next_act_pseq;
    logic [7:0] next_act_prate;
    logic [7:0] next_act_fbdiv;
    logic [7:0] next_act_fbseq;
    logic [2:0] next_act_fbrate;

    // ==================================================
    // pin synchronisers
    logic       lock_meta;
    logic       lock_sync;
    logic       osc_meta;
    logic       osc_sync;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            lock_meta <= 1'b0;
            lock_sync <= 1'b0;
            osc_meta  <= 1'b1;
            osc_sync  <= 1'b1;
        end
        else
        begin
            lock_meta <= pll_lock_i;
            lock_sync <= lock_meta;
            osc_meta  <= sysclk_on_osc_i;
            osc_sync  <= osc_meta;
        end
    end

    // ==================================================
    // register writes
    logic pll_off_req;

    always_comb
    begin
        pll_off_req  = !ctrl[FE_EN_BIT] || pwdn;
        next_ctrl    = ctrl;
        next_pseq    = pseq;
        next_prate   = prate;
        next_cpvco   = cpvco;
        next_fbdiv   = fbdiv;
        next_fbseq   = fbseq;
        next_oscbias = oscbias;
        next_frc_vco = frc_vco;
        next_pwdn    = pwdn;
        if (reg_wr_i)
        begin
            if (reg_addr_i == ADDR_CTRL)
            begin
                next_ctrl = reg_wdata_i;                        // R21
            end
            else if (reg_addr_i == ADDR_PSEQ)
            begin
                next_pseq = reg_wdata_i;
            end
            else if (reg_addr_i == ADDR_PRATE)
            begin
                next_prate = reg_wdata_i;
            end
            else if (reg_addr_i == ADDR_CPVCO)
            begin
                next_cpvco = reg_wdata_i & MASK_CPVCO;          // R20
            end
            else if (reg_addr_i == ADDR_FBDIV)
            begin
                next_fbdiv = reg_wdata_i & MASK_FBDIV;          // R20
            end
            else if (reg_addr_i == ADDR_FBSEQ)
            begin
                next_fbseq = reg_wdata_i;
            end
            else if (reg_addr_i == ADDR_OSCBIAS)
            begin
                next_oscbias = reg_wdata_i & MASK_OSCBIAS;      // R20
            end
            else if (reg_addr_i == ADDR_CLKSRC)
            begin
                next_frc_vco = reg_wdata_i[FRC_VCO_BIT];
                next_pwdn    = reg_wdata_i[PWDN_BIT];
            end
        end
        // hardware clear beats a host set in the same cycle
        if (!next_ctrl[FE_EN_BIT] || next_pwdn)
        begin
            next_frc_vco = 1'b0;                                // R14
        end
    end

    // ==================================================
    // staging: dividers see new settings only on a bias write
    always_comb
    begin
        next_act_pseq   = act_pseq;
        next_act_prate  = act_prate;
        next_act_fbdiv  = act_fbdiv;
        next_act_fbseq  = act_fbseq;
        next_act_fbrate = act_fbrate;
        if (reg_wr_i && reg_addr_i == ADDR_OSCBIAS)
        begin
            next_act_pseq   = pseq;                             // R23
            next_act_prate  = prate;
            next_act_fbdiv  = fbdiv;
            next_act_fbseq  = fbseq;
            next_act_fbrate = reg_wdata_i[2:0];                 // R6
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl       <= RST_CTRL;
            pseq       <= RST_PSEQ;
            prate      <= RST_PRATE;
            cpvco      <= RST_CPVCO;
            fbdiv      <= RST_FBDIV;
            fbseq      <= RST_FBSEQ;
            oscbias    <= RST_OSCBIAS;
            frc_vco    <= 1'b0;                                 // R14
            pwdn       <= 1'b0;
            act_pseq   <= RST_PSEQ;
            act_prate  <= RST_PRATE;
            act_fbdiv  <= RST_FBDIV;
            act_fbseq  <= RST_FBSEQ;
            act_fbrate <= RST_OSCBIAS[2:0];
        end
        else
        begin
            ctrl       <= next_ctrl;
            pseq       <= next_pseq;
            prate      <= next_prate;
            cpvco      <= next_cpvco;
            fbdiv      <= next_fbdiv;
            fbseq      <= next_fbseq;
            oscbias    <= next_oscbias;
            frc_vco    <= next_frc_vco;
            pwdn       <= next_pwdn;
            act_pseq   <= next_act_pseq;
            act_prate  <= next_act_prate;
            act_fbdiv  <= next_act_fbdiv;
            act_fbseq  <= next_act_fbseq;
            act_fbrate <= next_act_fbrate;
        end
    end

    // ==================================================
    // delayed pll power-down: hold power until the system clock is back
    // on the oscillator and a minimum hold has passed
    logic [3:0] hold_cnt;
    logic [3:0] next_hold_cnt;
    logic       pll_on;
    logic       next_pll_on;

    always_comb
    begin
        next_hold_cnt = hold_cnt;
        next_pll_on   = pll_on;
        if (!pll_off_req)
        begin
            next_hold_cnt = 4'h0;
            next_pll_on   = 1'b1;                               // R16
        end
        else if (pll_on)
        begin
            if (hold_cnt < PWR_HOLD_CYC)
            begin
                next_hold_cnt = hold_cnt + 4'h1;
            end
            else if (osc_sync)
            begin
                next_pll_on = 1'b0;                             // R15 R16
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            hold_cnt <= 4'h0;
            pll_on   <= 1'b0;
        end
        else
        begin
            hold_cnt <= next_hold_cnt;
            pll_on   <= next_pll_on;
        end
    end

    // ==================================================
    // read data, registered
    logic [7:0] next_rdata;

    always_comb
    begin
        next_rdata = ZERO8;
        if (reg_addr_i == ADDR_CTRL)
        begin
            next_rdata = ctrl;
        end
        else if (reg_addr_i == ADDR_PSEQ)
        begin
            next_rdata = pseq;
        end
        else if (reg_addr_i == ADDR_PRATE)
        begin
            next_rdata = prate;
        end
        else if (reg_addr_i == ADDR_CPVCO)
        begin
            next_rdata = cpvco;
        end
        else if (reg_addr_i == ADDR_FBDIV)
        begin
            next_rdata = fbdiv;
        end
        else if (reg_addr_i == ADDR_FBSEQ)
        begin
            next_rdata = fbseq;
        end
        else if (reg_addr_i == ADDR_OSCBIAS)
        begin
            next_rdata = oscbias;
        end
        else if (reg_addr_i == ADDR_CLKSRC)
        begin
            next_rdata[FRC_VCO_BIT] = frc_vco;
            next_rdata[PWDN_BIT]    = pwdn;
            next_rdata[LOCK_BIT]    = lock_sync;                // R17
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            reg_rdata_o        <= ZERO8;
            osc_bias_o         <= RST_OSCBIAS[7:6];
            vco_range_o        <= RST_CPVCO[2:0];
            charge_pump_o      <= RST_CPVCO[7:4];
            sel_vco_o          <= 1'b0;
            front_end_enable_o <= 1'b0;
        end
        else
        begin
            reg_rdata_o        <= next_rdata;
            osc_bias_o         <= oscbias[XTAL_LSB +: 2];       // R8
            vco_range_o        <= cpvco[2:0];                   // R10
            charge_pump_o      <= cpvco[ICHP_LSB +: 4];         // R11
            sel_vco_o          <= frc_vco;                      // R13
            front_end_enable_o <= ctrl[FE_EN_BIT];              // R21
        end
    end

    assign pll_power_on_o = pll_on;
    assign trx_clk_run_o  = front_end_enable_o;

    // ==================================================
    // prescaler forms the pll reference; feedback divider after it
    pncc_nco_div u_prescaler (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .divisor_i  ({2'b00, act_prate[4:0]}),                  // R3 R18
        .sequence_i (act_pseq),
        .rate_i     (act_prate[RATE_LSB +: 3]),                 // R2
        .tick_o     (pll_ref_tick_o)
    );

    pncc_nco_div u_feedback (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .divisor_i  (act_fbdiv[6:0]),                           // R4
        .sequence_i (act_fbseq),                                // R5
        .rate_i     (act_fbrate),                               // R6
        .tick_o     (pll_fb_tick_o)
    );
endmodule

// ### design/pncc_pkg.sv
package pncc_pkg;
    // ==================================================
    // register addresses
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_PSEQ      = 8'h08;
    localparam logic [7:0] ADDR_PRATE     = 8'h09;
    localparam logic [7:0] ADDR_CPVCO     = 8'h0A;
    localparam logic [7:0] ADDR_FBDIV     = 8'h0B;
    localparam logic [7:0] ADDR_FBSEQ     = 8'h0C;
    localparam logic [7:0] ADDR_OSCBIAS   = 8'h0D;
    localparam logic [7:0] ADDR_CLKSRC    = 8'h0E;
    // ==================================================
    // reset values
    localparam logic [7:0] RST_CTRL       = 8'h08;
    localparam logic [7:0] RST_PSEQ       = 8'h00;
    localparam logic [7:0] RST_PRATE      = 8'h0A;
    localparam logic [7:0] RST_CPVCO      = 8'h22;
    localparam logic [7:0] RST_FBDIV      = 8'h12;
    localparam logic [7:0] RST_FBSEQ      = 8'h00;
    localparam logic [7:0] RST_OSCBIAS    = 8'h48;
    // ==================================================
    // writable bit masks; unused bits are dropped on write
    localparam logic [7:0] MASK_CPVCO     = 8'hF7;
    localparam logic [7:0] MASK_FBDIV     = 8'h7F;
    localparam logic [7:0] MASK_OSCBIAS   = 8'hC7;
    // ==================================================
    // field positions
    localparam int         FE_EN_BIT      = 7;
    localparam int         FRC_VCO_BIT    = 7;
    localparam int         PWDN_BIT       = 6;
    localparam int         LOCK_BIT       = 5;
    localparam int         RATE_LSB       = 5;
    localparam int         XTAL_LSB       = 6;
    localparam int         ICHP_LSB       = 4;
    localparam logic [2:0] RATE_OFF       = 3'h0;
    localparam logic [7:0] ZERO8          = 8'h00;
    // hold cycles counted after a power-down request before the pll may power off
    localparam logic [3:0] PWR_HOLD_CYC   = 4'h8;
endpackage

// ### design/pncc_nco_div.sv
`timescale 1ns/1ps
// fractional divider: period is divisor or divisor+1 per sequence bit
module pncc_nco_div
    import pncc_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // settings
    input  wire logic [6:0] divisor_i,
    input  wire logic [7:0] sequence_i,
    input  wire logic [2:0] rate_i,
    // output
    output logic            tick_o
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [2:0] idx;
    logic [2:0] next_idx;
    logic       next_tick;
    logic [7:0] period;

    always_comb
    begin
        // a zero rate disables the sequence so the plain divisor is used
        if (rate_i == RATE_OFF)
        begin
            period = {1'b0, divisor_i};                             // R1 R4
        end
        else
        begin
            period = {1'b0, divisor_i} + {7'h00, sequence_i[idx]}; // R22
        end
        next_cnt  = cnt + 8'h01;
        next_idx  = idx;
        next_tick = 1'b0;
        if (cnt + 8'h01 >= period)
        begin
            next_cnt  = ZERO8;
            next_tick = 1'b1;
            if (idx >= rate_i)
            begin
                next_idx = 3'h0;                                    // R2 R6
            end
            else
            begin
                next_idx = idx + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt    <= ZERO8;
            idx    <= 3'h0;
            tick_o <= 1'b0;
        end
        else
        begin
            cnt    <= next_cnt;
            idx    <= next_idx;
            tick_o <= next_tick;
        end
    end
endmodule

// ### test/pncc_top_chk.sv
`timescale 1ns/1ps
// ==================================================
// port-level checks of the clock control registers
module pncc_top_chk
    import pncc_pkg::*;
(
    // clock and reset
    input wire logic       clk_i,
    input wire logic       rst_i,
    // register port
    input wire logic       reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    // controls
    input wire logic [1:0] osc_bias_o,
    input wire logic [2:0] vco_range_o,
    input wire logic [3:0] charge_pump_o,
    input wire logic       pll_power_on_o,
    input wire logic       sel_vco_o,
    input wire logic       front_end_enable_o,
    input wire logic       trx_clk_run_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic wr_bias;
    logic wr_cpvco;
    assign wr_bias  = reg_wr_i && (reg_addr_i == ADDR_OSCBIAS);
    assign wr_cpvco = reg_wr_i && (reg_addr_i == ADDR_CPVCO);
    // the pll must stay powered for eight cycles after the front end drops
    sequence s_fe_off;
        $fell(front_end_enable_o) ##0 pll_power_on_o;
    endsequence
    property p_power_hold;
        s_fe_off |-> pll_power_on_o [*8];
    endproperty
    a_power_hold: assert property (p_power_hold) else $error("pll power dropped early");
    property p_fe_clears_force;
        !front_end_enable_o |=> !sel_vco_o;
    endproperty
    a_fe_clears_force: assert property (p_fe_clears_force) else $error("vco kept");
    property p_sel_needs_power;
        sel_vco_o |-> pll_power_on_o;
    endproperty
    a_sel_needs_power: assert property (p_sel_needs_power) else $error("vco unpowered");
    property p_power_cause;
        $rose(pll_power_on_o) |-> front_end_enable_o;
    endproperty
    a_power_cause: assert property (p_power_cause) else $error("power without fe");
    property p_trx;
        trx_clk_run_o == front_end_enable_o;
    endproperty
    a_trx: assert property (p_trx) else $error("trx clock mismatch");
    // a control write reaches the front-end enable two edges later
    property p_fe_write;
        reg_wr_i && (reg_addr_i == ADDR_CTRL) |->
            ##2 front_end_enable_o == $past(reg_wdata_i[FE_EN_BIT], 2);
    endproperty
    a_fe_write: assert property (p_fe_write) else $error("fe not from write");
    property p_unused;
        $past(reg_addr_i) == ADDR_CLKSRC |-> reg_rdata_o[4:0] == 5'h00;
    endproperty
    a_unused: assert property (p_unused) else $error("unused bits read set");
    property p_unmapped;
        $past(reg_addr_i) > ADDR_CLKSRC |-> reg_rdata_o == ZERO8;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    property p_bias_cause;
        $changed(osc_bias_o) |-> $past(wr_bias, 1) || $past(wr_bias, 2);
    endproperty
    a_bias_cause: assert property (p_bias_cause) else $error("bias moved alone");
    property p_cp_cause;
        $changed({charge_pump_o, vco_range_o}) |-> $past(wr_cpvco, 1) || $past(wr_cpvco, 2);
    endproperty
    a_cp_cause: assert property (p_cp_cause) else $error("vco moved alone");
endmodule
bind pncc_top pncc_top_chk i_pncc_top_chk (
    .clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .osc_bias_o(osc_bias_o), .vco_range_o(vco_range_o),
    .charge_pump_o(charge_pump_o), .pll_power_on_o(pll_power_on_o), .sel_vco_o(sel_vco_o),
    .front_end_enable_o(front_end_enable_o), .trx_clk_run_o(trx_clk_run_o)
);

// ### test/pncc_analog_model.sv
`timescale 1ns/1ps
// ==================================================
// pll lock and clock mux switch-over, deliberately slow
module pncc_analog_model
(
    input  wire logic clk_i,
    input  wire logic power_on_i,
    input  wire logic sel_vco_i,
    output logic      pll_lock_o,
    output logic      sysclk_on_osc_o
);
    logic [4:0] lock_cnt = 5'h00;
    logic [3:0] sw_sr    = 4'hF;
    always @(posedge clk_i)
    begin
        if (!power_on_i)
            lock_cnt <= 5'h00;
        else if (lock_cnt != 5'h1F)
            lock_cnt <= lock_cnt + 5'h01;
        sw_sr <= {sw_sr[2:0], !sel_vco_i};
    end
    assign pll_lock_o      = (lock_cnt >= 5'h14);
    assign sysclk_on_osc_o = sw_sr[3];
endmodule

// ### test/pncc_top_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module pncc_top_test;
    import pncc_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, lock, on_osc, rd_v = 1'b0, rd_q = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, e, d;
    logic [1:0] osc_bias_o;
    logic [2:0] vco_range_o;
    logic [3:0] charge_pump_o;
    logic pll_power_on_o, sel_vco_o, front_end_enable_o, trx_clk_run_o, ref_t, fb_t;
    logic [31:0] lfsr = 32'h00017115;
    logic [7:0] exp_q[$];
    logic [7:0] addrs[7] = '{ADDR_PSEQ, ADDR_PRATE, ADDR_CPVCO, ADDR_FBDIV, ADDR_FBSEQ,
                             ADDR_OSCBIAS, ADDR_CLKSRC};
    logic [7:0] rstv[7] = '{RST_PSEQ, RST_PRATE, RST_CPVCO, RST_FBDIV, RST_FBSEQ,
                            RST_OSCBIAS, 8'h00};
    logic [7:0] rmask[6] = '{8'hFF, 8'hFF, 8'hF7, 8'h7F, 8'hFF, 8'hC7};
    int fail_count = 0, compares = 0, cycles = 0, n;
    pncc_top i_pncc_top (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .pll_lock_i(lock), .sysclk_on_osc_i(on_osc), .osc_bias_o(osc_bias_o),
        .vco_range_o(vco_range_o), .charge_pump_o(charge_pump_o),
        .pll_power_on_o(pll_power_on_o), .sel_vco_o(sel_vco_o),
        .front_end_enable_o(front_end_enable_o), .trx_clk_run_o(trx_clk_run_o),
        .pll_ref_tick_o(ref_t), .pll_fb_tick_o(fb_t));
    pncc_analog_model i_pncc_analog_model (.clk_i(clk_i), .power_on_i(pll_power_on_o),
        .sel_vco_i(sel_vco_o), .pll_lock_o(lock), .sysclk_on_osc_o(on_osc));
    initial forever #10 clk_i = ~clk_i;
    // ==================================================
    // drivers and read scoreboard
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk_i);
        reg_addr_i <= a;
        rd_v <= 1'b1;
        exp_q.push_back(x);
        @(posedge clk_i);
        rd_v <= 1'b0;
    endtask
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // two tick periods back to back, so both sequence bits count once
    task automatic per2(input logic fb, output int s);
        int k;
        int c;
        k = 0;
        c = 0;
        s = 0;
        while (k < 3 && c < 400)
        begin
            @(negedge clk_i);
            c++;
            if (k > 0)
                s++;
            if ((fb ? fb_t : ref_t) === 1'b1)
                k++;
        end
    endtask
    always @(posedge clk_i)
    begin
        rd_q <= rd_v;
        if (rd_q)
        begin
            e = exp_q.pop_front();
            `CHK(reg_rdata_o, e)
        end
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        `CHK({osc_bias_o, vco_range_o, charge_pump_o}, {RST_OSCBIAS[7:6], RST_CPVCO[2:0], RST_CPVCO[7:4]})
        `CHK({pll_power_on_o, sel_vco_o, front_end_enable_o}, 3'h0)
        for (int i = 0; i < 7; i++)
            rd(addrs[i], rstv[i]);
        for (int r = 0; r < 4; r++)
            for (int i = 0; i < 6; i++)
            begin
                lfsr = lfsr_next(lfsr);
                d = (i == 2) ? (lfsr[7:0] & 8'hF7) : lfsr[7:0];
                wr(addrs[i], d);
                rd(addrs[i], d & rmask[i]);
                repeat (2) @(negedge clk_i);
                if (i == 2)
                    `CHK({charge_pump_o, vco_range_o}, {d[7:4], d[2:0]})
                if (i == 5)
                    `CHK(osc_bias_o, d[7:6])
            end
        wr(ADDR_CLKSRC, 8'hFF);
        rd(ADDR_CLKSRC, 8'h40);
        wr(8'h0F, 8'hFF);
        rd(8'h0F, ZERO8);
        wr(ADDR_CLKSRC, 8'h00);
        wr(ADDR_CTRL, 8'h80);
        repeat (40) @(negedge clk_i);
        `CHK(pll_power_on_o, 1'b1)
        wr(ADDR_CLKSRC, 8'h80);
        repeat (3) @(negedge clk_i);
        `CHK(sel_vco_o, 1'b1)
        rd(ADDR_CLKSRC, 8'hA0);
        wr(ADDR_CLKSRC, 8'hC0);
        repeat (3) @(negedge clk_i);
        `CHK({sel_vco_o, pll_power_on_o}, 2'h1)
        repeat (30) @(negedge clk_i);
        `CHK(pll_power_on_o, 1'b0)
        rd(ADDR_CLKSRC, 8'h40);
        wr(ADDR_CLKSRC, 8'h80);
        repeat (40) @(negedge clk_i);
        wr(ADDR_CTRL, 8'h00);
        repeat (3) @(negedge clk_i);
        `CHK({sel_vco_o, trx_clk_run_o}, 2'h0)
        repeat (30) @(negedge clk_i);
        `CHK(pll_power_on_o, 1'b0)
        wr(ADDR_FBDIV, 8'h05);
        wr(ADDR_FBSEQ, 8'h01);
        // known active prescaler before the staging checks; lowest bias for the clock input
        wr(ADDR_PRATE, 8'h04);
        wr(ADDR_OSCBIAS, 8'h01);
        for (int i = 0; i < 3; i++)
        begin
            wr(ADDR_PSEQ, (i == 0) ? 8'hFF : 8'h01 << (i - 1) | 8'h01);
            wr(ADDR_PRATE, (i == 0) ? 8'h04 : 8'h24);
            repeat (20) @(negedge clk_i);
            per2(1'b0, n);
            `CHK(n, (i == 2) ? 9 : 8)
            wr(ADDR_OSCBIAS, 8'h41);
            repeat (20) @(negedge clk_i);
            per2(1'b0, n);
            `CHK(n, 8 + i)
        end
        per2(1'b1, n);
        `CHK(n, 11)
        repeat (4) @(posedge clk_i);
        print_verdict();
    end
endmodule
